/* rtl/serdes_rx_clocking_consts.vh */
// offsets, fields, reset values and ratios for the receive clocking block
`ifndef SERDES_RX_CLOCKING_CONSTS_VH
`define SERDES_RX_CLOCKING_CONSTS_VH

// ********************
// register offsets
// ********************
`define ADDR_IRQ_ENABLE_LINK      12'h01F
`define ADDR_IRQ_STATUS_LINK      12'h023
`define ADDR_SERIAL_POWER_CTRL    12'h200
`define ADDR_LANE_POWER_DOWN      12'h201
`define ADDR_RECOVERY_RESET_CTRL  12'h206
`define ADDR_RECOVERY_SAMPLING    12'h230
`define ADDR_EQUALIZER_CTRL       12'h268
`define ADDR_LANE_PLL_CTRL        12'h280
`define ADDR_LANE_PLL_STATUS      12'h281
`define ADDR_LANE_PLL_DIVIDER     12'h289

// ********************
// field positions
// ********************
`define BIT_IRQ_PLL_LOCK          2
`define BIT_IRQ_PLL_LOST          3
`define BIT_SERIAL_POWER_OFF      0
`define BIT_RECOVERY_RESET        0
`define BIT_HALF_RATE             5
`define BIT_OVERSAMPLE            1
`define BIT_EQ_SEL_LO             6
`define BIT_PLL_ENABLE            0
`define BIT_PLL_RECAL             2
`define BIT_STAT_LOCK             0
`define BIT_STAT_CAL_OK           3
`define BIT_STAT_BAND_HIGH        4
`define BIT_STAT_BAND_LOW         5

// ********************
// field encodings
// ********************
`define DIV_SEL_BY1               2'h2
`define DIV_SEL_BY2               2'h1
`define DIV_SEL_BY4               2'h0
`define EQ_SEL_LOW_POWER          2'h1
`define EQ_SEL_NORMAL             2'h0

// ********************
// reset values
// ********************
`define RST_IRQ_ENABLE_LINK       8'h00
`define RST_SERIAL_POWER_CTRL     8'h01
`define RST_LANE_POWER_DOWN       8'h00
`define RST_GENERAL               8'h00

// ********************
// rate ratios, counted in lane bit times, bytes per processing tick in bytes
// ********************
`define BITS_PER_BYTE             4'hA
`define BYTES_PER_PCLK            3'h4
`define BITS_PER_REFERENCE        6'h28

`endif

/* rtl/lane_phase_tracker.v */
// per-lane sampling phase tracker of the recovery stage
`timescale 1ns/1ps

module lane_phase_tracker #(
	parameter PHASE_W = 2
) (
	input  wire               clk_sys_i,
	input  wire               rst_n_i,
	input  wire               active_i,
	input  wire               sample_i,
	input  wire [PHASE_W-1:0] slot_i,
	output reg  [PHASE_W-1:0] phase_o
);

	reg                prev_q;
	wire [PHASE_W-1:0] target;

	// edges should sit half a window away from the sampling point
	assign target = slot_i + {1'b1, {(PHASE_W-1){1'b0}}};

	// ********************
	// phase stepping
	// ********************
	// one step per edge keeps noise on a single edge from jumping the phase
	always @(posedge clk_sys_i) begin
		if (!rst_n_i || !active_i) begin
			prev_q  <= 1'b0;
			phase_o <= {PHASE_W{1'b0}};
		end else begin
			prev_q <= sample_i;
			if (prev_q != sample_i && phase_o != target) begin
				if ((target - phase_o) < {1'b1, {(PHASE_W-1){1'b0}}})
					phase_o <= phase_o + {{(PHASE_W-1){1'b0}}, 1'b1};
				else
					phase_o <= phase_o - {{(PHASE_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // lane_phase_tracker

/* rtl/serdes_rx_clocking_setup.v */
// register file and clock-rate logic of the serial receiver clocking
`timescale 1ns/1ps
`include "serdes_rx_clocking_consts.vh"

module serdes_rx_clocking_setup #(
	parameter LANES   = 8,
	parameter PHASE_W = 2
) (
	input  wire               clk_sys_i,
	input  wire               rst_n_i,
	// register port
	input  wire [11:0]        reg_addr_i,
	input  wire               reg_wr_i,
	input  wire [7:0]         reg_wdata_i,
	input  wire               reg_rd_i,
	output reg  [7:0]         reg_rdata_o,
	output reg                reg_rvalid_o,
	// frame size, octets per frame per lane
	input  wire [4:0]         octets_per_frame_i,
	// analog lane PLL status
	input  wire               pll_locked_i,
	input  wire               pll_cal_done_i,
	input  wire               pll_band_high_i,
	input  wire               pll_band_low_i,
	// sampled serial lanes
	input  wire [LANES-1:0]   serial_lane_input_i,
	// PLL control
	output wire               pll_enable_o,
	output reg                pll_recal_o,
	output reg  [2:0]         reference_divide_factor_o,
	output reg                pfd_tick_o,
	output reg                quadrature_clk_o,
	// derived rate strobes
	output reg                byte_tick_o,
	output reg                processing_clock_tick_o,
	output reg                frame_tick_o,
	// recovery and lanes
	output wire               half_rate_sampling_on_o,
	output wire               double_oversample_on_o,
	output wire               recovery_reset_o,
	output wire [LANES-1:0]   lane_powered_o,
	output wire [LANES*PHASE_W-1:0] lane_phase_o,
	output wire               equalizer_low_power_o,
	output wire               irq_link_o
);

	// ********************
	// registers
	// ********************
	// software-visible control bits
	reg  [7:0]         irq_enable_link_q;
	reg  [7:0]         irq_status_link_q;
	reg                serial_power_off_q;
	reg  [LANES-1:0]   lane_power_off_mask_q;
	reg                recovery_reset_q;
	reg  [7:0]         recovery_sampling_ctrl_q;
	reg  [1:0]         equalizer_power_select_q;
	reg  [7:0]         lane_pll_ctrl_q;
	reg  [1:0]         pll_divide_select_q;

	// sticky flags and edge history
	reg                band_high_q;
	reg                band_low_q;
	reg                lock_prev_q;

	// rate counters: bit times, bytes, frame octets, processing ticks and slots
	reg  [3:0]         bit_cnt_q;
	reg  [2:0]         byte_cnt_q;
	reg  [4:0]         frame_cnt_q;
	reg  [2:0]         pfd_cnt_q;
	reg  [PHASE_W-1:0] slot_q;

	// read path
	reg  [7:0]         pll_status;
	reg  [7:0]         rdata_d;

	// decoded strobes and edges
	wire               wr_irq_status;
	wire               lock_rise;
	wire               lock_fall;
	wire               recal_start;
	wire               byte_end;
	wire               pclk_end;
	wire               serial_up;

	// ********************
	// local constants
	// ********************
	localparam [3:0] BYTE_LAST = `BITS_PER_BYTE - 4'h1;
	localparam [2:0] PCLK_LAST = `BYTES_PER_PCLK - 3'h1;

	// write decode and lock edges; lock is compared with the
	// last cycle, so a one-cycle dropout raises both events
	assign wr_irq_status = reg_wr_i && reg_addr_i == `ADDR_IRQ_STATUS_LINK;
	assign lock_rise     = pll_locked_i && !lock_prev_q;
	assign lock_fall     = !pll_locked_i && lock_prev_q;
	assign recal_start   = reg_wr_i && reg_addr_i == `ADDR_LANE_PLL_CTRL &&
		reg_wdata_i[`BIT_PLL_RECAL] && !lane_pll_ctrl_q[`BIT_PLL_RECAL];
	assign serial_up     = !serial_power_off_q;

	// ********************
	// register writes
	// ********************
	// no ordering check on enable versus divider: a wrong order simply
	// switches the running divider to the new factor at once, mid-count
	// writes to unmapped addresses are dropped without notice
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_enable_link_q        <= `RST_IRQ_ENABLE_LINK;
			// interface starts powered off until software clears it
			serial_power_off_q       <= 1'b1;
			lane_power_off_mask_q    <= {LANES{1'b0}};
			recovery_reset_q         <= 1'b0;
			recovery_sampling_ctrl_q <= `RST_GENERAL;
			equalizer_power_select_q <= `EQ_SEL_NORMAL;
			lane_pll_ctrl_q          <= `RST_GENERAL;
			pll_divide_select_q      <= `DIV_SEL_BY4;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				`ADDR_IRQ_ENABLE_LINK:     irq_enable_link_q <= reg_wdata_i;
				`ADDR_SERIAL_POWER_CTRL:
					serial_power_off_q <= reg_wdata_i[`BIT_SERIAL_POWER_OFF];
				`ADDR_LANE_POWER_DOWN:
					lane_power_off_mask_q <= reg_wdata_i[LANES-1:0];
				`ADDR_RECOVERY_RESET_CTRL:
					recovery_reset_q <= reg_wdata_i[`BIT_RECOVERY_RESET];
				`ADDR_RECOVERY_SAMPLING:   recovery_sampling_ctrl_q <= reg_wdata_i;
				`ADDR_EQUALIZER_CTRL:
					equalizer_power_select_q <= reg_wdata_i[`BIT_EQ_SEL_LO+1:`BIT_EQ_SEL_LO];
				`ADDR_LANE_PLL_CTRL:       lane_pll_ctrl_q <= reg_wdata_i;
				`ADDR_LANE_PLL_DIVIDER:    pll_divide_select_q <= reg_wdata_i[1:0];
				// the status register is read-only, so its writes land here
				default: ;
			endcase
		end
	end

	// ********************
	// lock events and band-edge flags
	// ********************
	// write one to clear; a new event in the clearing cycle still lands
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_status_link_q <= 8'h00;
			lock_prev_q       <= 1'b0;
			band_high_q       <= 1'b0;
			band_low_q        <= 1'b0;
			pll_recal_o       <= 1'b0;
		end else begin
			// remember lock for the edge detectors
			// status bits without a source here stay at zero
			lock_prev_q <= pll_locked_i;
			irq_status_link_q[`BIT_IRQ_PLL_LOCK] <= lock_rise ||
				(irq_status_link_q[`BIT_IRQ_PLL_LOCK] &&
				!(wr_irq_status && reg_wdata_i[`BIT_IRQ_PLL_LOCK]));
			irq_status_link_q[`BIT_IRQ_PLL_LOST] <= lock_fall ||
				(irq_status_link_q[`BIT_IRQ_PLL_LOST] &&
				!(wr_irq_status && reg_wdata_i[`BIT_IRQ_PLL_LOST]));
			// flags hold until a recalibration begins, band hit wins
			// a start is a fresh 0->1 write of the recal bit
			band_high_q <= pll_band_high_i || (band_high_q && !recal_start);
			band_low_q  <= pll_band_low_i || (band_low_q && !recal_start);
			pll_recal_o <= recal_start;
		end
	end

	// level interrupt: any enabled status bit holds it high
	assign irq_link_o = |(irq_status_link_q & irq_enable_link_q);

	// ********************
	// derived rate strobes
	// ********************
	// one system clock stands for one lane bit time; byte strobe
	// every ten bits, processing strobe every four bytes
	assign byte_end = bit_cnt_q == BYTE_LAST;
	assign pclk_end = byte_end && byte_cnt_q == PCLK_LAST;

	// counters restart on power-down, so the strobes keep no
	// phase across a power cycle
	always @(posedge clk_sys_i) begin
		if (!rst_n_i || !serial_up) begin
			bit_cnt_q               <= 4'h0;
			byte_cnt_q              <= 3'h0;
			frame_cnt_q             <= 5'h00;
			byte_tick_o             <= 1'b0;
			processing_clock_tick_o <= 1'b0;
			frame_tick_o            <= 1'b0;
		end else begin
			bit_cnt_q   <= byte_end ? 4'h0 : bit_cnt_q + 4'h1;
			byte_tick_o <= byte_end;
			if (byte_end)
				byte_cnt_q <= pclk_end ? 3'h0 : byte_cnt_q + 3'h1;
			processing_clock_tick_o <= pclk_end;
			// a frame size of zero is treated as one octet; a size change
			// needs no clear, the >= compare folds the count back
			if (byte_end) begin
				if (frame_cnt_q + 5'h01 >= octets_per_frame_i)
					frame_cnt_q <= 5'h00;
				else
					frame_cnt_q <= frame_cnt_q + 5'h01;
			end
			frame_tick_o <= byte_end && (frame_cnt_q + 5'h01 >= octets_per_frame_i);
		end
	end

	// ********************
	// reference divider and quadrature clock
	// ********************
	// code 3 is unused and falls back to the slowest reference
	always @* begin
		case (pll_divide_select_q)
			`DIV_SEL_BY1: reference_divide_factor_o = 3'h1;
			`DIV_SEL_BY2: reference_divide_factor_o = 3'h2;
			`DIV_SEL_BY4: reference_divide_factor_o = 3'h4;
			default:      reference_divide_factor_o = 3'h4;
		endcase
	end

	// enable only reaches the PLL while the interface is up
	assign pll_enable_o = lane_pll_ctrl_q[`BIT_PLL_ENABLE] && serial_up;

	// the reference is the processing tick, so the divider counts those
	// counter clears while disabled, so a new factor starts clean
	always @(posedge clk_sys_i) begin
		if (!rst_n_i || !pll_enable_o) begin
			pfd_cnt_q        <= 3'h0;
			pfd_tick_o       <= 1'b0;
			quadrature_clk_o <= 1'b0;
		end else begin
			// tick lands with the processing tick that ends a count
			pfd_tick_o <= 1'b0;
			if (pclk_end) begin
				if (pfd_cnt_q + 3'h1 >= reference_divide_factor_o) begin
					pfd_cnt_q  <= 3'h0;
					pfd_tick_o <= 1'b1;
				end else begin
					pfd_cnt_q <= pfd_cnt_q + 3'h1;
				end
			end
			// oscillator halved; only runs once lock is reported
			// one toggle per system clock stands for the halved oscillator
			if (pll_locked_i)
				quadrature_clk_o <= !quadrature_clk_o;
		end
	end

	// ********************
	// recovery stage and lanes
	// ********************
	// sampling modes pass straight through; a legal pair for the
	// lane rate is up to the host, nothing here checks it
	assign half_rate_sampling_on_o = recovery_sampling_ctrl_q[`BIT_HALF_RATE];
	assign double_oversample_on_o  = recovery_sampling_ctrl_q[`BIT_OVERSAMPLE];
	assign recovery_reset_o        = recovery_reset_q;
	assign lane_powered_o          = serial_up ? ~lane_power_off_mask_q : {LANES{1'b0}};
	assign equalizer_low_power_o   = equalizer_power_select_q == `EQ_SEL_LOW_POWER;

	// shared slot counter gives every tracker the same time base
	// free-running; only its relative phase matters
	always @(posedge clk_sys_i) begin
		if (!rst_n_i)
			slot_q <= {PHASE_W{1'b0}};
		else
			slot_q <= slot_q + {{(PHASE_W-1){1'b0}}, 1'b1};
	end

	// one tracker per lane, each with its own edge history;
	// a tracker clears while its lane is off, the recovery
	// stage is held in reset, or the PLL is unlocked
	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : g_lane
			lane_phase_tracker #(
				.PHASE_W (PHASE_W)
			) u_track (
				.clk_sys_i (clk_sys_i),
				.rst_n_i   (rst_n_i),
				.active_i  (lane_powered_o[g] && !recovery_reset_q && pll_locked_i),
				.sample_i  (serial_lane_input_i[g]),
				.slot_i    (slot_q),
				.phase_o   (lane_phase_o[g*PHASE_W +: PHASE_W])
			);
		end
	endgenerate

	// ********************
	// register reads
	// ********************
	// lock and calibration follow the analog inputs live;
	// only the band flags are latched
	always @* begin
		pll_status = 8'h00;
		pll_status[`BIT_STAT_LOCK]      = pll_locked_i;
		pll_status[`BIT_STAT_CAL_OK]    = pll_cal_done_i;
		pll_status[`BIT_STAT_BAND_HIGH] = band_high_q;
		pll_status[`BIT_STAT_BAND_LOW]  = band_low_q;
		case (reg_addr_i)
			`ADDR_IRQ_ENABLE_LINK:     rdata_d = irq_enable_link_q;
			`ADDR_IRQ_STATUS_LINK:     rdata_d = irq_status_link_q;
			`ADDR_SERIAL_POWER_CTRL:   rdata_d = {7'h00, serial_power_off_q};
			`ADDR_LANE_POWER_DOWN:     rdata_d = lane_power_off_mask_q;
			`ADDR_RECOVERY_RESET_CTRL: rdata_d = {7'h00, recovery_reset_q};
			`ADDR_RECOVERY_SAMPLING:   rdata_d = recovery_sampling_ctrl_q;
			`ADDR_EQUALIZER_CTRL:      rdata_d = {equalizer_power_select_q, 6'h00};
			`ADDR_LANE_PLL_CTRL:       rdata_d = lane_pll_ctrl_q;
			// read-only status, assembled above
			`ADDR_LANE_PLL_STATUS:     rdata_d = pll_status;
			`ADDR_LANE_PLL_DIVIDER:    rdata_d = {6'h00, pll_divide_select_q};
			// unmapped space reads as zero
			default:                   rdata_d = 8'h00;
		endcase
	end

	// registered answer one cycle after the strobe; data holds
	// until the next read so software may sample it late
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o  <= 8'h00;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i)
				reg_rdata_o <= rdata_d;
		end
	end

endmodule // serdes_rx_clocking_setup

/* verification/serdes_rx_clocking_setup_chk.sv */
// port-level assertion checker for the receive clocking block
`timescale 1ns/1ps

module serdes_rx_clocking_setup_chk (
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	input  wire       reg_rd_i,
	input  wire       pll_locked_i,
	input  wire [7:0] reg_rdata_o,
	input  wire       reg_rvalid_o,
	input  wire       pll_enable_o,
	input  wire       pll_recal_o,
	input  wire [2:0] reference_divide_factor_o,
	input  wire       pfd_tick_o,
	input  wire       quadrature_clk_o,
	input  wire       byte_tick_o,
	input  wire       processing_clock_tick_o,
	input  wire       frame_tick_o
);
	// ********************
	// shared clocking and sequences
	// ********************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// three settled cycles so both samples of the quadrature clock flop are enabled
	sequence en_lock3;
		(pll_enable_o && pll_locked_i)[*3];
	endsequence

	a_byte_period: assert property (byte_tick_o |-> ##10 byte_tick_o)
		else $error("byte tick period wrong");
	a_byte_quiet: assert property (byte_tick_o |=> (!byte_tick_o)[*8])
		else $error("byte tick too soon");
	a_pclk_period: assert property (processing_clock_tick_o |-> ##40 processing_clock_tick_o)
		else $error("processing tick period wrong");
	a_frame_on_byte: assert property (frame_tick_o |-> byte_tick_o)
		else $error("frame tick off byte tick");
	a_pfd_on_pclk: assert property (pfd_tick_o |-> processing_clock_tick_o)
		else $error("pfd tick without processing tick");
	a_div_legal: assert property (reference_divide_factor_o inside {3'h1, 3'h2, 3'h4})
		else $error("illegal divide factor");
	a_recal_single: assert property (pll_recal_o |=> !pll_recal_o)
		else $error("recal pulse too long");
	a_quad_toggle: assert property (en_lock3 |-> quadrature_clk_o != $past(quadrature_clk_o))
		else $error("quadrature clock stuck");
	a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
		else $error("read answer missing");
	a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
		else $error("read answer without read");
endmodule // serdes_rx_clocking_setup_chk

bind serdes_rx_clocking_setup serdes_rx_clocking_setup_chk u_chk (.clk_sys_i, .rst_n_i,
	.reg_rd_i, .pll_locked_i, .reg_rdata_o, .reg_rvalid_o, .pll_enable_o, .pll_recal_o,
	.reference_divide_factor_o, .pfd_tick_o, .quadrature_clk_o, .byte_tick_o,
	.processing_clock_tick_o, .frame_tick_o);

/* verification/lane_transmitter_model.sv */
// serial lane source standing in for the far transmitter
`timescale 1ns/1ps

module lane_transmitter_model #(
	parameter LANES = 8
) (
	input  wire             clk_sys_i,
	input  wire             rst_n_i,
	output reg  [LANES-1:0] serial_lane_input_o
);
	reg [15:0] lfsr_q;
	// each lane takes its own lfsr bit, so edges differ per lane
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			lfsr_q <= 16'hACE1;
			serial_lane_input_o <= {LANES{1'b0}};
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			serial_lane_input_o <= lfsr_q[LANES-1:0];
		end
	end
endmodule // lane_transmitter_model

/* verification/serdes_rx_clocking_setup_test.sv */
// self-checking bench for the receive clocking block
`timescale 1ns/1ps

module serdes_rx_clocking_setup_test;
	logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
	logic        pll_locked_i, pll_cal_done_i, pll_band_high_i, pll_band_low_i;
	logic [11:0] reg_addr_i;
	logic [7:0]  reg_wdata_i, reg_rdata_o, serial_lane_input_i, lane_powered_o, d;
	logic [4:0]  octets_per_frame_i;
	logic [2:0]  reference_divide_factor_o;
	logic [15:0] lane_phase_o;
	logic        pll_enable_o, pll_recal_o, pfd_tick_o, quadrature_clk_o, byte_tick_o;
	logic        processing_clock_tick_o, frame_tick_o, half_rate_sampling_on_o;
	logic        double_oversample_on_o, recovery_reset_o, equalizer_low_power_o, irq_link_o;
	logic [31:0] seed, v;
	logic [7:0]  mdl [int];
	int          n_mismatch, samples_checked, n;

	serdes_rx_clocking_setup u_serdes_rx_clocking_setup (.clk_sys_i, .rst_n_i, .reg_addr_i,
		.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .octets_per_frame_i,
		.pll_locked_i, .pll_cal_done_i, .pll_band_high_i, .pll_band_low_i,
		.serial_lane_input_i, .pll_enable_o, .pll_recal_o, .reference_divide_factor_o,
		.pfd_tick_o, .quadrature_clk_o, .byte_tick_o, .processing_clock_tick_o, .frame_tick_o,
		.half_rate_sampling_on_o, .double_oversample_on_o, .recovery_reset_o, .lane_powered_o,
		.lane_phase_o, .equalizer_low_power_o, .irq_link_o);
	lane_transmitter_model u_lane_transmitter_model (.clk_sys_i, .rst_n_i,
		.serial_lane_input_o(serial_lane_input_i));

	// ********************
	// helpers
	// ********************
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function logic tk(int k);
		case (k)
			0: return byte_tick_o;
			1: return processing_clock_tick_o;
			2: return frame_tick_o;
			3: return pfd_tick_o;
			default: return 1'b1;
		endcase
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// the model only tracks plain read-write registers
	task wr(input logic [11:0] a, input logic [7:0] w);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= w;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		if (mdl.exists(a)) mdl[a] = w;
		#1;
	endtask
	task rchk(input logic [11:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rvalid_o, 1'b1);
		chk(reg_rdata_o, e);
	endtask
	// ticks of b from one tick of a up to and including the next; bounded wait
	task gap(input int a, input int b, output int c);
		int w;
		c = 0;
		w = 0;
		do begin @(posedge clk_sys_i); #1; w++; end while (!tk(a) && w < 900);
		do begin @(posedge clk_sys_i); #1; w++; c += tk(b); end while (!tk(a) && w < 1800);
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// whole run is a few thousand cycles; this is far beyond it
	initial begin
		#100000;
		n_mismatch++;
		wrap_up();
	end

	// ********************
	// main sequence
	// ********************
	initial begin
		{rst_n_i, reg_wr_i, reg_rd_i, pll_locked_i, pll_cal_done_i} = 0;
		{pll_band_high_i, pll_band_low_i, reg_addr_i, reg_wdata_i} = 0;
		octets_per_frame_i = 5'h01;
		seed = 32'hFA2C;
		n_mismatch = 0;
		samples_checked = 0;
		mdl[12'h01F] = 0; mdl[12'h200] = 8'h01; mdl[12'h201] = 0; mdl[12'h206] = 0;
		mdl[12'h230] = 0; mdl[12'h268] = 0; mdl[12'h280] = 0; mdl[12'h289] = 0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		foreach (mdl[a]) rchk(a[11:0], mdl[a]);
		rchk(12'h123, 0);
		chk(lane_powered_o, 0);
		wr(12'h200, 0);
		chk(lane_powered_o, 8'hFF);
		$display("test power_up done");
		gap(0, 4, n); chk(n, 10);
		gap(1, 0, n); chk(n, 4);
		for (int f = 1; f <= 4; f *= 2) begin
			@(posedge clk_sys_i);
			octets_per_frame_i <= f[4:0];
			gap(2, 0, n);
			gap(2, 0, n);
			chk(n, f);
		end
		$display("test rates done");
		@(posedge clk_sys_i);
		pll_locked_i <= 1'b1;
		pll_cal_done_i <= 1'b1;
		rchk(12'h281, 8'h09);
		for (int s = 0; s < 4; s++) begin
			wr(12'h280, 8'h00);
			wr(12'h289, s[7:0]);
			wr(12'h280, 8'h01);
			chk(reference_divide_factor_o, s == 2 ? 1 : s == 1 ? 2 : 4);
			chk(pll_enable_o, 1'b1);
			gap(3, 1, n);
			gap(3, 1, n);
			chk(n, s == 2 ? 1 : s == 1 ? 2 : 4);
		end
		for (int b = 4; b < 6; b++) begin
			@(posedge clk_sys_i);
			pll_band_high_i <= (b == 4);
			pll_band_low_i <= (b == 5);
			@(posedge clk_sys_i);
			{pll_band_high_i, pll_band_low_i} <= 2'h0;
			rchk(12'h281, 8'h09 | (8'h01 << b));
			wr(12'h280, 8'h01);
			wr(12'h280, 8'h05);
			chk(pll_recal_o, 1'b1);
			rchk(12'h281, 8'h09);
		end
		$display("test pll done");
		wr(12'h023, 8'h0C);
		rchk(12'h023, 0);
		wr(12'h01F, 8'h0C);
		@(posedge clk_sys_i);
		pll_locked_i <= 1'b0;
		rchk(12'h023, 8'h08);
		chk(irq_link_o, 1'b1);
		wr(12'h023, 8'h08);
		chk(irq_link_o, 1'b0);
		wr(12'h01F, 0);
		@(posedge clk_sys_i);
		pll_locked_i <= 1'b1;
		rchk(12'h023, 8'h04);
		chk(irq_link_o, 1'b0);
		$display("test irq done");
		repeat (4) begin
			v = rnd();
			v[1] = v[1] && !v[5];
			wr(12'h230, v[7:0]);
			chk(half_rate_sampling_on_o, v[5]);
			chk(double_oversample_on_o, v[1]);
			wr(12'h201, v[15:8]);
			chk(lane_powered_o, v[15:8] ^ 8'hFF);
			wr(12'h268, {1'b0, v[16], v[21:16]});
			mdl[12'h268] = {1'b0, v[16], 6'h00}; // only the mode field is kept
			chk(equalizer_low_power_o, v[16]);
		end
		wr(12'h206, 8'h01);
		chk(recovery_reset_o, 1'b1);
		@(posedge clk_sys_i);
		#1;
		chk(lane_phase_o, 16'h0000);
		wr(12'h206, 8'h00);
		chk(recovery_reset_o, 1'b0);
		foreach (mdl[a]) rchk(a[11:0], mdl[a]);
		for (int i = 0; i < 8; i++)
			if (v[8+i]) chk(lane_phase_o[2*i +: 2], 2'h0);
		$display("test recovery done");
		wrap_up();
	end
endmodule // serdes_rx_clocking_setup_test
